// [clkctl_regs.svh]
`ifndef CLKCTL_REGS_SVH
`define CLKCTL_REGS_SVH
// Notes on behaviour
// - timer oscillator allowed on crystal pins only when internal RC is source
// - external timer clock select takes external clock on timer_osc_in
// - clock output fuse drives system clock on pin, even in reset
// - with division active, the clock pin carries the divided clock
// - prescaler divides io, adc, cpu and flash clocks for every source
// - no glitch and no period shorter than both settings on a change
// - new rate active after T1+T2 to T1+2*T2, two active edges between
// - enable bit updates only when other bits written zero together
// - enable clears four cycles after set or when division is written
// - rewriting enable inside its window neither restarts nor clears it
// - division field value n gives factor 2**n for 0..8, above reserved
// - reset loads division 0000, or 0011 if divide-by-eight fuse programmed
// - any division value accepted through the sequence whatever the fuse
// - trim register loads factory value at reset, software may rewrite
// - trim top bit picks low or high range, ranges overlap
// - lower seven trim bits tune monotonically inside the range

// ==========================================================================
// register map (byte addresses)
`define OFS_OSC_TRIM      12'h000
`define OFS_PRESCALE      12'h004
`define OFS_TIMER_OSC     12'h008
`define OFS_CLK_STATUS    12'h00c
// field positions
`define PC_ENABLE_BIT     7
`define TO_EXT_SEL_BIT    0
`define TO_REQ_BIT        1
// reset values and timing
`define DIV_RESET_PLAIN   4'h0
`define DIV_RESET_FUSE    4'h3
`define DIV_MAX           4'h8
`define CHANGE_WINDOW     3'h4
`endif

// [clkctl_pkg.sv]
package clkctl_pkg;
  // ========================================================================
  // types
  typedef logic [3:0] div_sel_t;
  typedef struct packed {
    logic rc_selected;
    logic timer_osc_req;
    logic ext_sel;
  } timer_osc_cfg_s;
  typedef enum logic [1:0] {ST_IDLE, ST_OPEN} change_e;
endpackage : clkctl_pkg

// [ripple_prescaler.sv]
`timescale 1ns/100ps
`default_nettype none
`include "clkctl_regs.svh"
// ==========================================================================
// power-of-two prescaler, counter clocked by the undivided source clock clk_sys
module ripple_prescaler
  import clkctl_pkg::*;
#(
  parameter int unsigned CW = 8
) (
  input  wire logic     clk_sys,
  input  wire logic     sys_rst,
  input  wire div_sel_t div_req,
  output logic          tick_en,
  output logic          clk_div,
  output div_sel_t      div_active
);
  logic [CW-1:0] cnt_r;
  logic [CW:0]   mask;

  // mask of the low bits that must all be one at the end of a divided period
  function automatic logic [CW:0] div_mask(input div_sel_t d);
    div_mask = ({{CW{1'b0}}, 1'b1} << d) - {{CW{1'b0}}, 1'b1};
  endfunction : div_mask

  assign mask = div_mask(div_active);

  // count free on the source rate
  always_ff @(posedge clk_sys) begin
    if (sys_rst) cnt_r <= '0;
    else if ((cnt_r & mask[CW-1:0]) == mask[CW-1:0]) cnt_r <= '0;
    else cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
  end

  // swap the setting only at a period boundary, so no runt period appears
  always_ff @(posedge clk_sys) begin
    if (sys_rst) div_active <= `DIV_RESET_PLAIN;
    else if ((cnt_r & mask[CW-1:0]) == mask[CW-1:0]) div_active <= div_req;
  end

  // one enable pulse per divided period, and a square-ish clock for the pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_en <= 1'b0;
      clk_div <= 1'b0;
    end else begin
      tick_en <= ((cnt_r & mask[CW-1:0]) == mask[CW-1:0]);
      // high for the first half of each divided period; factor one still toggles
      clk_div <= (div_active == 4'h0) ? ~clk_div :
                 ({1'b0, cnt_r & mask[CW-1:0]} < ((mask + {{CW{1'b0}}, 1'b1}) >> 1));
    end
  end
endmodule : ripple_prescaler
`default_nettype wire

// [clkctl.sv]
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "clkctl_regs.svh"
// ==========================================================================
// system clock control with apb register access
module clkctl
  import clkctl_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h80 // arbitrary default calibration
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        divide_by_eight_fuse,
  input  wire logic        clock_out_fuse,
  input  wire logic        rc_selected,
  input  wire logic        timer_osc_in,
  output logic             clock_out_pin,
  output logic             clock_out_oe_n,
  output logic             clk_tick_en,
  output logic [7:0]       oscillator_trim,
  output logic             timer_osc_enable,
  output logic             timer_osc_ext,
  output logic             timer_clk_sample
);
  logic           wr_en;
  logic           rd_en;
  logic           hit;
  logic [7:0]     wdat;
  logic           rst_seen_r;
  div_sel_t       div_sel_r;
  div_sel_t       div_active;
  change_e        chg_r;
  logic [2:0]     chg_cnt_r;
  timer_osc_cfg_s to_cfg_r;
  logic           tick;
  logic           clk_div;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wdat  = pwdata[7:0];
  assign hit   = (paddr == `OFS_OSC_TRIM) || (paddr == `OFS_PRESCALE) ||
                 (paddr == `OFS_TIMER_OSC) || (paddr == `OFS_CLK_STATUS);

  // ========================================================================
  // prescaler
  ripple_prescaler #(.CW(8)) u_pre (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .div_req   (div_sel_r),
    .tick_en   (tick),
    .clk_div   (clk_div),
    .div_active(div_active)
  );

  // ========================================================================
  // change sequence: enable opens a four-cycle window
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chg_r     <= ST_IDLE;
      chg_cnt_r <= 3'h0;
    end else begin
      case (chg_r)
        ST_IDLE: begin
          if (wr_en && paddr == `OFS_PRESCALE && wdat == 8'h80) begin
            chg_r     <= ST_OPEN;
            chg_cnt_r <= `CHANGE_WINDOW;
          end
        end
        ST_OPEN: begin
          // a rewrite of the enable neither extends nor clears it
          if (wr_en && paddr == `OFS_PRESCALE && !wdat[`PC_ENABLE_BIT]) chg_r <= ST_IDLE;
          else if (chg_cnt_r == 3'h1) chg_r <= ST_IDLE;
          chg_cnt_r <= chg_cnt_r - 3'h1;
        end
        default: chg_r <= ST_IDLE;
      endcase
    end
  end

  // division field: fuse picks reset value; reserved codes are refused
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_sel_r  <= `DIV_RESET_PLAIN;
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r)
        div_sel_r <= divide_by_eight_fuse ? `DIV_RESET_FUSE : `DIV_RESET_PLAIN;
      else if (chg_r == ST_OPEN && wr_en && paddr == `OFS_PRESCALE &&
               !wdat[`PC_ENABLE_BIT] && wdat[3:0] <= `DIV_MAX)
        div_sel_r <= wdat[3:0];
    end
  end

  // trim and timer oscillator configuration
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oscillator_trim <= FACTORY_TRIM;
      to_cfg_r        <= '0;
    end else begin
      to_cfg_r.rc_selected <= rc_selected;
      if (wr_en && paddr == `OFS_OSC_TRIM) oscillator_trim <= wdat;
      if (wr_en && paddr == `OFS_TIMER_OSC) begin
        to_cfg_r.ext_sel       <= wdat[`TO_EXT_SEL_BIT];
        to_cfg_r.timer_osc_req <= wdat[`TO_REQ_BIT];
      end
    end
  end

  // timer oscillator pins only granted while the rc oscillator drives the system
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_osc_enable <= 1'b0;
      timer_osc_ext    <= 1'b0;
      timer_clk_sample <= 1'b0;
    end else begin
      timer_osc_enable <= to_cfg_r.timer_osc_req && to_cfg_r.rc_selected;
      timer_osc_ext    <= to_cfg_r.timer_osc_req && to_cfg_r.rc_selected && to_cfg_r.ext_sel;
      timer_clk_sample <= to_cfg_r.ext_sel ? timer_osc_in : 1'b0;
    end
  end

  // clock output: no reset branch, and under sys_rst it toggles itself, so it keeps running even in reset
  always_ff @(posedge clk_sys) begin
    clock_out_oe_n <= !clock_out_fuse;
    clock_out_pin  <= clock_out_fuse ? (sys_rst ? ~clock_out_pin : clk_div) : 1'b0;
  end

  // divided enable for downstream clock domains
  always_ff @(posedge clk_sys) begin
    if (sys_rst) clk_tick_en <= 1'b0;
    else clk_tick_en <= tick;
  end

  // apb slave: zero wait states, error on unmapped address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `OFS_OSC_TRIM:   prdata <= {24'h0, oscillator_trim};
          `OFS_PRESCALE:   prdata <= {24'h0, chg_r == ST_OPEN, 3'h0, div_sel_r};
          `OFS_TIMER_OSC:  prdata <= {30'h0, to_cfg_r.timer_osc_req, to_cfg_r.ext_sel};
          `OFS_CLK_STATUS: prdata <= {26'h0, timer_osc_enable, to_cfg_r.rc_selected, div_active};
          default:         prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule : clkctl
`default_nettype wire

// [clkctl_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// ====
// port checks for clkctl
module clkctl_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clock_out_fuse,
  input wire logic        rc_selected,
  input wire logic        clock_out_oe_n,
  input wire logic [7:0]  oscillator_trim,
  input wire logic        timer_osc_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // access phase and trim write, named once
  logic acc;
  logic tw;
  assign acc = psel && penable;
  assign tw  = acc && pwrite && paddr == 12'h000;
  // zero wait states: the first access cycle answers
  ready_on_time_a: assert property (acc |-> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (acc && paddr > 12'h00c |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr <= 12'h00c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  trim_write_a: assert property (tw |=> oscillator_trim == $past(pwdata[7:0]))
    else $error("trim write lost");
  trim_hold_a: assert property (!tw |=> $stable(oscillator_trim))
    else $error("trim changed unasked");
  // the pin must stay driven while the fuse holds, checked outside reset only
  clkout_drive_a: assert property (clock_out_fuse && $past(clock_out_fuse) |-> !clock_out_oe_n)
    else $error("clock pin not driven");
  // the grant sits two registers behind the pin, so look two samples back
  rc_gate_a: assert property (!rc_selected && !$past(rc_selected) && !$past(rc_selected, 2) |-> !timer_osc_enable)
    else $error("timer oscillator without rc");
  cover property (tw);
  cover property (acc && pslverr);
  cover property (timer_osc_enable);
endmodule : clkctl_monitor
`default_nettype wire

// [test_system_clock_prescaler_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_system_clock_prescaler_ctrl;
  logic        clk_sys = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic        pready, pslverr, divide_by_eight_fuse = '0, clock_out_fuse = '0, rc_selected = '0;
  logic        timer_osc_in = '0, clock_out_pin, clock_out_oe_n, clk_tick_en, timer_osc_enable;
  logic        timer_osc_ext, timer_clk_sample;
  logic [7:0]  oscillator_trim;
  logic [32:0] expq[$];
  int          errors = 0, samples_checked = 0, n;
  clkctl #(.FACTORY_TRIM(8'h3c)) i_clkctl (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .divide_by_eight_fuse, .clock_out_fuse, .rc_selected,
    .timer_osc_in, .clock_out_pin, .clock_out_oe_n, .clk_tick_en, .oscillator_trim,
    .timer_osc_enable, .timer_osc_ext, .timer_clk_sample);
  initial forever #50 clk_sys = ~clk_sys;
  // ====
  // verdict
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // reset with a chosen fuse, then leave the settle edge the design asks for
  task rst(input logic f);
    sys_rst <= 1'b1;
    divide_by_eight_fuse <= f;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : rst
  // one apb transfer; reads queue their expected {pslverr, prdata}
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    k = 0;
    if (!w) expq.push_back(e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++k < 16);
    if (k >= 16) begin
      errors++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // skip the switch-over ticks, then measure one settled divided period
  task gap(input int e);
    int k, g;
    for (k = 0; k < 4; k++) begin
      g = 0;
      do @(posedge clk_sys); while (clk_tick_en !== 1'b1 && ++g < 600);
    end
    `CHK(g + 1, e)
    if (g >= 600) summarize();
  endtask : gap
  // read answers are matched against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) `CHK({pslverr, prdata}, expq.pop_front())
  end
  // ====
  // main sequence
  initial begin
    r = $urandom(70);
    rst(1'b0);
    apb(1'b0, 12'h004, '0, 33'h0);
    rst(1'b1);
    apb(1'b0, 12'h004, '0, 33'h3);
    apb(1'b0, 12'h000, '0, 33'h3c);
    gap(8);
    // every legal factor, entered while the fuse is programmed
    for (n = 8; n >= 0; n--) begin
      apb(1'b1, 12'h004, 32'h80, '0);
      apb(1'b1, 12'h004, 32'(n), '0);
      apb(1'b0, 12'h004, '0, 33'(n));
      gap(1 << n);
      apb(1'b0, 12'h00c, '0, 33'(n));
    end
    $display("prescale factors done");
    // refused: no window, stray bit, reserved value
    apb(1'b1, 12'h004, 32'h05, '0);
    apb(1'b1, 12'h004, 32'h81, '0);
    apb(1'b1, 12'h004, 32'h02, '0);
    apb(1'b1, 12'h004, 32'h80, '0);
    apb(1'b1, 12'h004, 32'h09, '0);
    apb(1'b0, 12'h004, '0, 33'h0);
    apb(1'b1, 12'h004, 32'h80, '0);
    apb(1'b0, 12'h004, '0, 33'h80);
    apb(1'b0, 12'h004, '0, 33'h0);
    // a rewrite must not stretch the window
    apb(1'b1, 12'h004, 32'h80, '0);
    apb(1'b1, 12'h004, 32'h80, '0);
    apb(1'b1, 12'h004, 32'h06, '0);
    apb(1'b0, 12'h004, '0, 33'h0);
    $display("change protection done");
    repeat (3) begin
      r = $urandom;
      apb(1'b1, 12'h000, r, '0); // no nvm write runs here
      apb(1'b0, 12'h000, '0, {25'h0, r[7:0]});
    end
    // timer oscillator only while rc is the source
    rc_selected <= 1'b1; // main clock far above the timer clock
    apb(1'b1, 12'h008, 32'h3, '0);
    apb(1'b0, 12'h008, '0, 33'h3);
    `CHK(timer_osc_ext, 1'b1)
    apb(1'b0, 12'h00c, '0, 33'h30);
    rc_selected <= 1'b0;
    repeat (2) @(posedge clk_sys);
    apb(1'b0, 12'h00c, '0, 33'h0);
    clock_out_fuse <= 1'b1;
    apb(1'b0, 12'h010, '0, 33'h100000000);
    `CHK(clock_out_oe_n, 1'b0)
    @(posedge clk_sys);
    r[0] = clock_out_pin;
    @(posedge clk_sys);
    `CHK(clock_out_pin, ~r[0])
    $display("timer, trim and pin done");
    summarize();
  end
endmodule : test_system_clock_prescaler_ctrl
bind clkctl clkctl_monitor i_clkctl_monitor (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .clock_out_fuse, .rc_selected, .clock_out_oe_n, .oscillator_trim,
  .timer_osc_enable);
`default_nettype wire
